// >>> bench/slcd_glass_model.sv
// Purpose: passive panel glass that shows which segments are lit
// Assumes: at most one common line is driven at a time
// Notes: com_seen gathers the commons driven since the last clr
`timescale 1ns/1ps
module slcd_glass_model (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // panel lines
  input  wire logic [3:0]  common_line,
  input  wire logic [39:0] segment_line,
  // observation
  input  wire logic        clr,
  output logic [3:0][39:0] lit,
  output logic [3:0]       com_seen
);
  // a driven common shows every segment whose bit is one
  always_ff @(posedge aclk) begin
    for (int c = 0; c < 4; c++) begin
      if (common_line[c]) begin
        lit[c] <= segment_line;
      end
    end
  end
  // collect the commons that a frame scans
  always_ff @(posedge aclk) begin
    if (!aresetn || clr) begin
      com_seen <= 4'h0;
    end else begin
      com_seen <= com_seen | common_line;
    end
  end
endmodule

// >>> bench/tb_top.sv
// Purpose: register and panel timing checks for the segment block
// Assumes: short drive-time values so pulses fit a prescaled period
// Notes: expected figures are worked out here from K, N and D
`timescale 1ns/1ps
module tb_top;
  import slcd_pkg::*;
  logic             aclk = 1'b0;
  logic             aresetn = 1'b0;
  logic [11:0]      awaddr = 12'h0, araddr = 12'h0;
  logic [31:0]      wdata = 32'h0, rdata;
  logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic             arvalid = 1'b0, rready = 1'b0, clr = 1'b0;
  logic             awready, wready, bvalid, arready, rvalid;
  logic [1:0]       bresp, rresp, rs;
  logic [3:0]       com, vmax, seen;
  logic [39:0]      seg, rv, e;
  logic [3:0][39:0] lit;
  logic             pclk, drv_on, fs, fsf, blk;
  logic [7:0]       pat [20];
  int               fails = 0, tests_run = 0, p, w;
  int nt [8] = '{16, 64, 128, 256, 512, 1024, 2048, 4096};
  int dv [7] = '{4, 2, 3, 5, 6, 7, 20};
  logic [7:0] ridx [5] = '{IDX_CCR, IDX_RATE, IDX_CTRL, IDX_SEG0, IDX_SEGN};
  logic [7:0] fr [5] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h07};
  logic [1:0] fd [5] = '{2'h0, 2'h2, 2'h3, 2'h1, 2'h3};

  // device under test with short drive times
  slcd_top #(.DRV_CYC({18'h14, 18'h7, 18'h6, 18'h5, 18'h3, 18'h2, 18'h4}))
  slcd_top_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .common_line(com), .segment_line(seg), .panel_max_voltage(vmax),
    .driver_on(drv_on), .prescaled_panel_clock(pclk), .frame_start(fs),
    .frame_start_flag(fsf), .blanked(blk)
  );
  // passive glass on the panel lines
  slcd_glass_model slcd_glass_model_i (
    .aclk(aclk), .aresetn(aresetn), .common_line(com),
    .segment_line(seg), .clr(clr), .lit(lit), .com_seen(seen)
  );

  // 125 MHz clock
  always #4 aclk = ~aclk;

  // compare and count
  task automatic chk(input string n, input logic [39:0] s, x);
    tests_run++;
    if (s !== x) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask
  // register write, address and data offered together
  task automatic wr(input logic [7:0] i, d, output logic [1:0] r);
    logic aw_t, w_t, b_t;
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= {2'h0, i, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid;
      r = bresp;
      n++;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end while (!b_t && n < 1000);
    bready <= 1'b0;
    if (!b_t) fails++;
  endtask
  // register read
  task automatic rd(input logic [7:0] i, output logic [39:0] d,
                    output logic [1:0] r);
    logic ar_t, r_t;
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= {2'h0, i, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar_t = arvalid && arready;
      r_t = rvalid;
      d = {8'h0, rdata};
      r = rresp;
      n++;
      @(posedge aclk);
      if (ar_t) arvalid <= 1'b0;
    end while (!r_t && n < 1000);
    rready <= 1'b0;
    if (!r_t) fails++;
  endtask
  // cycles until the next frame start pulse
  task automatic wframe(output int c);
    c = 0;
    do begin
      @(negedge aclk);
      c++;
    end while (fs !== 1'b1 && c < 5000);
    if (fs !== 1'b1) fails++;
  endtask
  // width of the next driver pulse
  task automatic won(output int c);
    int n;
    n = 0;
    c = 0;
    while (drv_on !== 1'b0 && n < 5000) begin
      @(negedge aclk);
      n++;
    end
    while (drv_on !== 1'b1 && n < 5000) begin
      @(negedge aclk);
      n++;
    end
    while (drv_on === 1'b1 && c < 5000) begin
      @(negedge aclk);
      c++;
    end
  endtask
  // closing report
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog at 40000 cycles, about three times what the tests need
  initial begin
    #320000;
    fails++;
    print_verdict();
  end

  // test sequence
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ridx[k]) begin
      rd(ridx[k], rv, rs);
      chk("reset value", rv, 40'h0);
    end
    wr(IDX_CCR, 8'hff, rs);
    rd(IDX_CCR, rv, rs);
    chk("contrast reserved", rv, 40'hef);
    wr(IDX_RATE, 8'hff, rs);
    rd(IDX_RATE, rv, rs);
    chk("rate reserved", rv, 40'h77);
    wr(8'h00, 8'h5a, rs);
    chk("unmapped write", 40'(rs), 40'(RESP_SLVERR));
    rd(8'h00, rv, rs);
    chk("unmapped read", 40'(rs), 40'(RESP_SLVERR));
    wr(IDX_CCR, 8'h00, rs);
    $display("test registers done");
    for (int i = 0; i < SEG_BYTES; i++) begin
      pat[i] = 8'(i * 29 + 7);
      wr(IDX_SEG0 + 8'(i), pat[i], rs);
      rd(IDX_SEG0 + 8'(i), rv, rs);
      chk("segment memory", rv, {32'h0, pat[i]});
    end
    $display("test memory done");
    for (int k = 0; k < 5; k++) begin
      wr(IDX_RATE, fr[k], rs);
      wr(IDX_CTRL, {5'h0, fd[k], 1'b0}, rs);
      wframe(p);
      wframe(p);
      w = (fd[k] == DUTY_THIRD ? 6 : 8) * nt[fr[k][6:4]] * (fr[k][2:0] + 1);
      chk("frame period", 40'(p), 40'(w));
      @(posedge aclk);
      clr <= 1'b1;
      @(posedge aclk);
      clr <= 1'b0;
      wframe(p);
      chk("commons used", 40'(seen), 40'((1 << (fd[k] + 1)) - 1));
    end
    $display("test frame timing done");
    wr(IDX_RATE, 8'h00, rs);
    wr(IDX_CTRL, 8'h06, rs);
    for (int v = 0; v < 16; v++) begin
      wframe(p);
      wr(IDX_CCR, 8'(v), rs);
      chk("contrast held", 40'(vmax), 40'(v == 0 ? 0 : v - 1));
      wframe(p);
      chk("contrast applied", 40'(vmax), 40'(v));
    end
    $display("test contrast done");
    for (int c = 0; c < COMS; c++) begin
      for (int b = 0; b < 5; b++) begin
        e[8*b+:8] = pat[5*c+b];
      end
      chk("lit segments", lit[c], e);
    end
    wframe(p);
    wr(IDX_SEG0, ~pat[0], rs);
    chk("segments held", 40'({com, seg[7:0]}), 40'({4'h1, pat[0]}));
    wframe(p);
    chk("segments reload", 40'({com, seg[7:0]}), 40'({4'h1, ~pat[0]}));
    $display("test segments done");
    wr(IDX_RATE, 8'h01, rs);
    for (int d = 0; d < 8; d++) begin
      wr(IDX_CCR, {3'(d), 5'h0}, rs);
      won(w);
      p = (d == 7 || dv[d % 7] > 16) ? 16 : dv[d % 7];
      chk("drive time", 40'(w), 40'(p));
    end
    wr(IDX_CCR, 8'h20, rs);
    wr(IDX_CTRL, 8'h00, rs);
    won(w);
    chk("static drive time", 40'(w), 40'h10);
    // prescaled clock pulse spacing, N 16 times D 2
    @(negedge aclk);
    while (pclk !== 1'b1) @(negedge aclk);
    p = 0;
    do begin
      @(negedge aclk);
      p++;
    end while (pclk !== 1'b1 && p < 5000);
    chk("prescaled period", 40'(p), 40'h20);
    $display("test drive time done");
    wframe(p);
    rd(IDX_CTRL, rv, rs);
    chk("frame flag set", rv, 40'h10);
    chk("frame flag pin", 40'(fsf), 40'h1);
    wr(IDX_CTRL, 8'h10, rs);
    rd(IDX_CTRL, rv, rs);
    chk("frame flag clear", rv, 40'h0);
    chk("flag pin clear", 40'(fsf), 40'h0);
    wr(IDX_CTRL, 8'h07, rs);
    chk("blank waits", 40'(blk), 40'h0);
    wframe(p);
    chk("blank lines", 40'({blk, com}), 40'h10);
    chk("blank segments", seg, 40'h0);
    wr(IDX_CCR, 8'h40, rs);
    won(w);
    chk("blank drive time", 40'(w), 40'h10);
    $display("test blank and flag done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(IDX_CCR, rv, rs);
    chk("reset again", rv, 40'h0);
    chk("reset outputs", 40'({blk, vmax, fsf}), 40'h0);
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule

// >>> verilog/slcd_pkg.sv
// Purpose: constants and types for the segment panel timing block
// Assumes: one 125 MHz clock that also serves as the panel source clock
// Notes: a register's byte address is four times its index
// How it works
// - post divider divides prescaler output by its field value plus one
// - one frame lasts K times N times D source clock cycles
// - K is eight for static, half and quarter duty, six for third
// - reserved contrast bit 4 and frame rate bit 3 read as zero
// - drive-time field picks a nominal driver on-time, code 7 half period
// - driver on-time never exceeds half a prescaled clock period
// - static duty or blanking forces on-time to half a prescaled period
// - a new drive-time code applies at the next prescaled clock tick, not at a frame edge
// - four-bit contrast code selects the panel maximum voltage
// - contrast code is held pending and applied at the next frame start
// - a one bit in segment memory energises its segment
// - unused segment memory bits stay ordinary read/write storage
// - five bytes per common, segment s at bit s mod 8 of byte s div 8
// - two-bit duty field selects one to four common lines
// - three-bit tap field selects prescaler ratio 16 up to 4096
// - blanking waits for frame end, then grounds all lines
// - frame start flag rises as displayed data reloads from memory
package slcd_pkg;
  localparam int ADDR_W  = 12;
  localparam int CLK_MHZ = 125;
  // register indexes
  localparam logic [7:0] IDX_SEG0 = 8'hd0;
  localparam logic [7:0] IDX_SEGN = 8'he3;
  localparam logic [7:0] IDX_CTRL = 8'he4;
  localparam logic [7:0] IDX_RATE = 8'he6;
  localparam logic [7:0] IDX_CCR  = 8'he7;
  localparam int SEG_BYTES = 20;
  localparam int SEG_W     = 40;
  localparam int COMS      = 4;
  // writable bits, reset value
  localparam logic [7:0] RATE_WMASK = 8'h77;
  localparam logic [7:0] CCR_WMASK  = 8'hef;
  localparam logic [7:0] REG_RST    = 8'h00;
  localparam logic [2:0] DRV_HALF   = 3'h7;
  // frame factors
  localparam logic [3:0] K_THIRD = 4'h6;
  localparam logic [3:0] K_OTHER = 4'h8;
  // prescaler ratios by tap code
  localparam logic [7:0][12:0] TAP_RATIO = {13'h1000, 13'h0800,
    13'h0400, 13'h0200, 13'h0100, 13'h0080, 13'h0040, 13'h0010};
  // nominal drive times in microseconds
  localparam int DRV_US_0 = 300;
  localparam int DRV_US_1 = 70;
  localparam int DRV_US_2 = 150;
  localparam int DRV_US_3 = 450;
  localparam int DRV_US_4 = 575;
  localparam int DRV_US_5 = 850;
  localparam int DRV_US_6 = 1150;
  localparam logic [6:0][17:0] DRV_CYC_DEF = {18'(DRV_US_6 * CLK_MHZ),
    18'(DRV_US_5 * CLK_MHZ), 18'(DRV_US_4 * CLK_MHZ),
    18'(DRV_US_3 * CLK_MHZ), 18'(DRV_US_2 * CLK_MHZ),
    18'(DRV_US_1 * CLK_MHZ), 18'(DRV_US_0 * CLK_MHZ)};
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    DUTY_STATIC = 2'h0, DUTY_HALF = 2'h1,
    DUTY_THIRD  = 2'h2, DUTY_QUARTER = 2'h3
  } slcd_duty_t;
  typedef enum logic [2:0] {
    WR_IDLE = 3'b001, WR_DO = 3'b010, WR_RESP = 3'b100
  } slcd_wr_t;
  typedef struct packed {
    logic [2:0] rsv_hi;
    logic       flag;
    logic       rsv;
    slcd_duty_t duty;
    logic       blank;
  } slcd_ctrl_t;
  typedef struct packed {
    logic       rsv_hi;
    logic [2:0] tap;
    logic       rsv;
    logic [2:0] div;
  } slcd_rate_t;
  typedef struct packed {
    logic [2:0] drv;
    logic       rsv;
    logic [3:0] vsel;
  } slcd_ccr_t;
endpackage

// >>> verilog/slcd_top.sv
// Purpose: frame timing, drive time, contrast and segment memory
// Assumes: AXI4-Lite master keeps one write and one read in flight
// Notes: all panel outputs are logic levels for the waveform stage
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
module slcd_top #(
  parameter logic [6:0][17:0] DRV_CYC = slcd_pkg::DRV_CYC_DEF
) (
  // clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // write address channel
  input  wire logic [slcd_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  // write data channel
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  // write response channel
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // read address channel
  input  wire logic [slcd_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  // read data channel
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // panel side
  output logic [slcd_pkg::COMS-1:0]        common_line,
  output logic [slcd_pkg::SEG_W-1:0]       segment_line,
  output logic [3:0]                       panel_max_voltage,
  output logic                             driver_on,
  output logic                             prescaled_panel_clock,
  output logic                             frame_start,
  output logic                             frame_start_flag,
  output logic                             blanked
);
  import slcd_pkg::*;

  slcd_ctrl_t             ctrl_q;
  slcd_rate_t             rate_q;
  slcd_ccr_t              ccr_q;
  slcd_ctrl_t             wctl;
  slcd_wr_t               wr_st_q;
  logic [7:0]             mem_q [SEG_BYTES];
  logic [SEG_BYTES*8-1:0] shadow_q;
  logic [SEG_BYTES*8-1:0] shadow_d;
  logic [11:0]            ps_cnt_q;
  logic [2:0]             cd_cnt_q;
  logic [2:0]             ph_q;
  logic [2:0]             ph_d;
  logic [17:0]            dr_cnt_q;
  logic [17:0]            dr_cnt_d;
  logic [17:0]            drv_nom;
  logic [12:0]            n_w;
  logic [3:0]             d_w;
  logic [16:0]            per_w;
  logic [15:0]            half_w;
  logic [3:0]             k_w;
  logic [1:0]             com_d;
  logic                   pre_tick;
  logic                   pclk_tick;
  logic                   fs;
  logic                   blank_q;
  logic                   blank_d;
  logic [3:0]             vsel_q;
  logic [COMS-1:0]        common_q;
  logic [SEG_W-1:0]       segment_q;
  logic                   drive_q;
  logic                   pclk_q;
  logic                   fs_q;
  logic                   awready_q;
  logic                   wready_q;
  logic                   bvalid_q;
  logic [1:0]             bresp_q;
  logic                   aw_got_q;
  logic                   w_got_q;
  logic [ADDR_W-1:0]      awaddr_q;
  logic [7:0]             wdat_q;
  logic                   wstb_q;
  logic                   arready_q;
  logic                   rvalid_q;
  logic [1:0]             rresp_q;
  logic [31:0]            rdata_q;
  logic                   wr_go;
  logic                   wr_hit;
  logic [7:0]             widx;
  logic [7:0]             ridx;
  logic [7:0]             rd_byte;
  logic                   rd_hit;

  // frame factor for a duty setting
  function automatic logic [3:0] frame_k(input slcd_duty_t duty);
    frame_k = (duty == DUTY_THIRD) ? K_THIRD : K_OTHER;
  endfunction

  // active common line for a frame phase
  function automatic logic [1:0] com_of(input logic [2:0] ph,
                                        input slcd_duty_t duty);
    case (duty)
      DUTY_STATIC: com_of = 2'h0;
      DUTY_HALF:   com_of = {1'b0, ph[2]};
      default:     com_of = ph[2:1];
    endcase
  endfunction

  // segment bits of one common from the packed memory image
  function automatic logic [SEG_W-1:0] pick_seg(
      input logic [SEG_BYTES*8-1:0] img, input logic [1:0] c);
    pick_seg = img[SEG_W-1:0];
    for (int i = 1; i < COMS; i++) begin
      if (c == 2'(i)) begin
        pick_seg = img[i*SEG_W +: SEG_W];
      end
    end
  endfunction

  // prescaler ratio, post divide and half period
  assign n_w    = TAP_RATIO[rate_q.tap];
  assign d_w    = {1'b0, rate_q.div} + 4'h1;
  assign per_w  = 17'(n_w) * 17'(d_w);
  assign half_w = per_w[16:1];
  assign k_w    = frame_k(ctrl_q.duty);

  // tick strobes
  assign pre_tick  = ({1'b0, ps_cnt_q} >= n_w - 13'h1);
  assign pclk_tick = pre_tick && (cd_cnt_q >= rate_q.div);
  assign fs = pclk_tick && ({1'b0, ph_q} >= k_w - 4'h1);

  // prescaler and post divider counters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ps_cnt_q <= 12'h000;
      cd_cnt_q <= 3'h0;
    end else begin
      ps_cnt_q <= pre_tick ? 12'h000 : ps_cnt_q + 12'h001;
      if (pclk_tick) begin
        cd_cnt_q <= 3'h0;
      end else if (pre_tick) begin
        cd_cnt_q <= cd_cnt_q + 3'h1;
      end
    end
  end

  // frame phase, K prescaled periods per frame
  always_comb begin
    ph_d = ph_q;
    if (fs) begin
      ph_d = 3'h0;
    end else if (pclk_tick) begin
      ph_d = ph_q + 3'h1;
    end
  end
  assign com_d   = com_of(ph_d, ctrl_q.duty);
  assign blank_d = fs ? ctrl_q.blank : blank_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph_q    <= 3'h0;
      blank_q <= 1'b0;
    end else begin
      ph_q    <= ph_d;
      blank_q <= blank_d;
    end
  end

  // memory image reloads at frame start only
  always_comb begin
    shadow_d = shadow_q;
    if (fs) begin
      for (int i = 0; i < SEG_BYTES; i++) begin
        shadow_d[i*8 +: 8] = mem_q[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shadow_q <= '0;
    end else begin
      shadow_q <= shadow_d;
    end
  end

  // line levels, grounded while blanked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      common_q  <= '0;
      segment_q <= '0;
    end else if (blank_d) begin
      common_q  <= '0;
      segment_q <= '0;
    end else begin
      common_q  <= 4'(4'h1 << com_d);
      segment_q <= pick_seg(shadow_d, com_d);
    end
  end

  // contrast applies at frame start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vsel_q <= 4'h0;
    end else if (fs) begin
      vsel_q <= ccr_q.vsel;
    end
  end

  // driver on-time per transition
  always_comb begin
    drv_nom  = (ccr_q.drv == DRV_HALF) ? {2'h0, half_w}
                                      : DRV_CYC[ccr_q.drv];
    dr_cnt_d = dr_cnt_q;
    if (pclk_tick) begin
      if (ctrl_q.duty == DUTY_STATIC || blank_q) begin
        dr_cnt_d = {2'h0, half_w};
      end else if (drv_nom > {2'h0, half_w}) begin
        dr_cnt_d = {2'h0, half_w};
      end else begin
        dr_cnt_d = drv_nom;
      end
    end else if (dr_cnt_q != 18'h0) begin
      dr_cnt_d = dr_cnt_q - 18'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dr_cnt_q <= 18'h0;
      drive_q  <= 1'b0;
      pclk_q   <= 1'b0;
      fs_q     <= 1'b0;
    end else begin
      dr_cnt_q <= dr_cnt_d;
      drive_q  <= (dr_cnt_d != 18'h0);
      pclk_q   <= pclk_tick;
      fs_q     <= fs;
    end
  end

  // write channel
  // unmapped writes, aliases above the decoded window included, change nothing
  assign wr_go  = (wr_st_q == WR_DO) && wr_hit;
  assign widx   = awaddr_q[9:2];
  assign wr_hit = (awaddr_q[11:10] == 2'h0) &&
                  ((widx >= IDX_SEG0 && widx <= IDX_SEGN) ||
                   widx == IDX_CTRL || widx == IDX_RATE ||
                   widx == IDX_CCR);
  assign wctl   = slcd_ctrl_t'(wdat_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_st_q   <= WR_IDLE;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      awaddr_q  <= '0;
      wdat_q    <= 8'h00;
      wstb_q    <= 1'b0;
    end else begin
      case (wr_st_q)
        WR_IDLE: begin
          if (s_axi_awvalid && awready_q) begin
            awaddr_q  <= s_axi_awaddr;
            awready_q <= 1'b0;
            aw_got_q  <= 1'b1;
          end
          if (s_axi_wvalid && wready_q) begin
            wdat_q   <= s_axi_wdata[7:0];
            wstb_q   <= s_axi_wstrb[0];
            wready_q <= 1'b0;
            w_got_q  <= 1'b1;
          end
          if (aw_got_q && w_got_q) begin
            wr_st_q <= WR_DO;
          end
        end
        WR_DO: begin
          bvalid_q <= 1'b1;
          bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
          aw_got_q <= 1'b0;
          w_got_q  <= 1'b0;
          wr_st_q  <= WR_RESP;
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            wr_st_q   <= WR_IDLE;
          end
        end
        default: wr_st_q <= WR_IDLE;
      endcase
    end
  end

  // register file and segment memory
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= slcd_ctrl_t'(REG_RST);
      rate_q <= slcd_rate_t'(REG_RST);
      ccr_q  <= slcd_ccr_t'(REG_RST);
      for (int i = 0; i < SEG_BYTES; i++) begin
        mem_q[i] <= REG_RST;
      end
    end else begin
      if (wr_go && wstb_q && widx == IDX_CTRL) begin
        ctrl_q.blank <= wctl.blank;
        ctrl_q.duty  <= wctl.duty;
      end
      // set wins over a write-one clear
      ctrl_q.flag <= fs | (ctrl_q.flag &
        ~(wr_go && wstb_q && widx == IDX_CTRL && wctl.flag));
      if (wr_go && wstb_q && widx == IDX_RATE) begin
        rate_q <= slcd_rate_t'(wdat_q & RATE_WMASK);
      end
      if (wr_go && wstb_q && widx == IDX_CCR) begin
        ccr_q <= slcd_ccr_t'(wdat_q & CCR_WMASK);
      end
      for (int i = 0; i < SEG_BYTES; i++) begin
        if (wr_go && wstb_q && wr_hit && widx == IDX_SEG0 + 8'(i)) begin
          mem_q[i] <= wdat_q;
        end
      end
    end
  end

  // read decode
  always_comb begin
    ridx    = s_axi_araddr[9:2];
    rd_byte = 8'h00;
    rd_hit  = (s_axi_araddr[11:10] == 2'h0);
    if (ridx == IDX_CTRL) begin
      rd_byte = ctrl_q;
    end else if (ridx == IDX_RATE) begin
      rd_byte = rate_q;
    end else if (ridx == IDX_CCR) begin
      rd_byte = ccr_q;
    end else if (ridx >= IDX_SEG0 && ridx <= IDX_SEGN) begin
      rd_byte = mem_q[5'(ridx - IDX_SEG0)];
    end else begin
      rd_hit = 1'b0;
    end
    if (!rd_hit) begin
      rd_byte = 8'h00;
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_q   <= {24'h000000, rd_byte};
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // outputs from flops
  assign s_axi_awready         = awready_q;
  assign s_axi_wready          = wready_q;
  assign s_axi_bvalid          = bvalid_q;
  assign s_axi_bresp           = bresp_q;
  assign s_axi_arready         = arready_q;
  assign s_axi_rvalid          = rvalid_q;
  assign s_axi_rresp           = rresp_q;
  assign s_axi_rdata           = rdata_q;
  assign common_line           = common_q;
  assign segment_line          = segment_q;
  assign panel_max_voltage     = vsel_q;
  assign driver_on             = drive_q;
  assign prescaled_panel_clock = pclk_q;
  assign frame_start           = fs_q;
  assign frame_start_flag      = ctrl_q.flag;
  assign blanked               = blank_q;

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_post_div_end: assert property (
    pclk_tick |-> pre_tick && cd_cnt_q >= rate_q.div)
    else $error("post divider tick off count");
  a_rsv_read_zero: assert property (
    s_axi_arvalid && arready_q && rd_hit && ridx == IDX_CCR
    |=> !rdata_q[4])
    else $error("reserved contrast bit read nonzero");
  a_rsv_rate_zero: assert property (
    s_axi_arvalid && arready_q && rd_hit && ridx == IDX_RATE
    |=> !rdata_q[3] && !rdata_q[7])
    else $error("reserved rate bit read nonzero");
  a_drive_clamp: assert property (
    pclk_tick |=> dr_cnt_q <= {2'h0, $past(half_w)})
    else $error("drive time above half period");
  a_static_half: assert property (
    pclk_tick && (ctrl_q.duty == DUTY_STATIC || blank_q)
    |=> dr_cnt_q == {2'h0, $past(half_w)} ##1 drive_q)
    else $error("static or blank drive not half period");
  a_contrast_hold: assert property (
    fs |=> vsel_q == $past(ccr_q.vsel))
    else $error("contrast not applied at frame start");
  a_contrast_stable: assert property (
    !fs |=> $stable(vsel_q))
    else $error("contrast changed outside frame start");
  a_blank_ground: assert property (
    blank_q |-> common_q == '0 && segment_q == '0)
    else $error("lines not grounded while blanked");
  a_flag_on_frame: assert property (
    fs |=> ctrl_q.flag && fs_q && shadow_q == $past(shadow_d))
    else $error("frame start flag missed");
  a_shadow_hold: assert property (
    !fs |=> $stable(shadow_q))
    else $error("displayed data changed mid frame");
endmodule
